// file: rtl/dcam_pkg.sv
// Contract
// - two alarms evaluated independently, own threshold and count, shared configuration
// - static mode compares selected source against threshold with configured polarity
// - threshold uses selected source format; alarm one [11:8], alarm two [15:12]
// - rate mode alarms when source changes by threshold over programmed samples
// - sample count is bits [7:0]; 0x00 and 0x01 mean one; upper ignored
// - selector: 0000 off, 0001 coarse rate, 0010 temperature, 0011 diagnostic word
// - configuration bit 7 mode alarm two, bit 6 alarm one; one is rate
// - bit 5 direction alarm two, bit 4 alarm one; one means above
// - bit 3 selects filtered rate data, only when rate is the source
// - bits [2:0]: indicator enable, polarity, line two or line one
// - alarm flags appear in diagnostic status word bits [9:8]
// - all alarm registers reset to zero; alarms off, indicator off
// - indicator yields a line claimed by data ready, beats general use
package dcam_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_THR_ONE = 8'h10;
    localparam logic [7:0] OFS_THR_TWO = 8'h12;
    localparam logic [7:0] OFS_CNT_ONE = 8'h14;
    localparam logic [7:0] OFS_CNT_TWO = 8'h16;
    localparam logic [7:0] OFS_CONFIG  = 8'h18;
    localparam logic [15:0] REG_RESET  = 16'h0000;
    // configuration field positions
    localparam int SEL_TWO_HI  = 15;
    localparam int SEL_TWO_LO  = 12;
    localparam int SEL_ONE_HI  = 11;
    localparam int SEL_ONE_LO  = 8;
    localparam int BIT_MODE_TWO = 7;
    localparam int BIT_MODE_ONE = 6;
    localparam int BIT_DIR_TWO  = 5;
    localparam int BIT_DIR_ONE  = 4;
    localparam int BIT_FILTER   = 3;
    localparam int BIT_IND_EN   = 2;
    localparam int BIT_IND_POL  = 1;
    localparam int BIT_IND_LINE = 0;
    // alarm flag positions in the diagnostic word
    localparam int DIAG_FLAG_ONE = 8;
    localparam int DIAG_FLAG_TWO = 9;
    // sample count field and history depth
    localparam int CNT_W      = 8;
    localparam int HIST_DEPTH = 256;
    // source selector codes
    typedef enum logic [3:0] {
        DCAM_SRC_OFF  = 4'h0,
        DCAM_SRC_RATE = 4'h1,
        DCAM_SRC_TEMP = 4'h2,
        DCAM_SRC_DIAG = 4'h3
    } dcam_src_t;
endpackage

// file: rtl/dcam_channel.sv
// one alarm condition: history, comparison and flag
module dcam_channel (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        sample_valid,
    input  wire logic        enable,
    input  wire logic        is_signed,
    input  wire logic [15:0] value,
    input  wire logic [15:0] threshold,
    input  wire logic [15:0] count_reg,
    input  wire logic        rate_mode,
    input  wire logic        above,
    output logic             flag
);
    logic [15:0] hist [dcam_pkg::HIST_DEPTH];
    logic [7:0]  wr_ptr;
    logic [7:0]  fill;
    logic [7:0]  eff_count;
    logic [15:0] past;
    logic signed [16:0] cur_x;
    logic signed [16:0] past_x;
    logic signed [16:0] thr_x;
    logic signed [16:0] cmp_x;
    logic        hit;
    logic        ready;
    logic [15:0] last_value;

    // zero and one both mean one sample, upper byte ignored
    assign eff_count = (count_reg[7:0] == 8'h00) ? 8'h01 : count_reg[7:0];
    assign past      = hist[8'(wr_ptr - eff_count)];
    // widen to 17 bits in the source's own format
    assign cur_x  = is_signed ? {value[15], value} : {1'b0, value};
    assign past_x = is_signed ? {past[15], past} : {1'b0, past};
    assign thr_x  = is_signed ? {threshold[15], threshold} : {1'b0, threshold};
    assign cmp_x  = rate_mode ? 17'(cur_x - past_x) : cur_x;
    assign hit    = above ? (cmp_x > thr_x) : (cmp_x < thr_x);
    assign ready  = !rate_mode || (fill >= eff_count);

    // history entries, one per sample
    genvar i;
    generate
        for (i = 0; i < dcam_pkg::HIST_DEPTH; i++) begin : g_hist
            always_ff @(posedge mclk or posedge rst) begin
                if (rst)
                    hist[i] <= 16'h0000;
                else if (sample_valid && enable && wr_ptr == 8'(i))
                    hist[i] <= value;
            end
        end
    endgenerate

    // write pointer and fill level, restarted when disabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 8'h00;
            fill   <= 8'h00;
        end else if (!enable) begin
            wr_ptr <= 8'h00;
            fill   <= 8'h00;
        end else if (sample_valid) begin
            wr_ptr <= wr_ptr + 8'h01;
            if (fill != 8'hff)
                fill <= fill + 8'h01;
        end
    end

    // flag updated once per sample
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            flag <= 1'b0;
        else if (!enable)
            flag <= 1'b0;
        else if (sample_valid)
            flag <= hit && ready;
    end

    // latest stored sample, a second view of the history for checking
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            last_value <= 16'h0000;
        else if (sample_valid && enable)
            last_value <= value;
    end

    property p_disabled_clear;
        @(posedge mclk) disable iff (rst) !enable |=> !flag;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear) else $error("flag set while off");

    property p_static_cmp;
        @(posedge mclk) disable iff (rst)
            (sample_valid && enable && !rate_mode) |=> flag == $past(hit);
    endproperty
    a_static_cmp: assert property (p_static_cmp) else $error("static compare wrong");

    property p_hold_between;
        @(posedge mclk) disable iff (rst)
            (!sample_valid && enable) |=> flag == $past(flag);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("flag moved off sample");

    sequence s_one_step;
        sample_valid && enable && rate_mode && count_reg[7:0] <= 8'h01 && fill != 8'h00;
    endsequence
    property p_rate_one;
        @(posedge mclk) disable iff (rst)
            s_one_step |-> past == last_value;
    endproperty
    a_rate_one: assert property (p_rate_one) else $error("count zero not one");
endmodule // dcam_channel

// file: rtl/dcam_monitor.sv
// dual condition alarm monitor
module dcam_monitor (
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    // sensor data, one sample per strobe
    input  wire logic        sample_valid,
    input  wire logic [15:0] rate_output_coarse,
    input  wire logic [15:0] rate_output_filtered,
    input  wire logic [15:0] temperature_output,
    input  wire logic [15:0] diag_status_in,
    // data ready claim
    input  wire logic        data_ready_enable,
    input  wire logic        data_ready_line_two,
    // results
    output logic [1:0]       alarm_flags,
    output logic [15:0]      diagnostic_status_word,
    output logic             digital_line_one_out,
    output logic             digital_line_one_oe,
    output logic             digital_line_two_out,
    output logic             digital_line_two_oe
);
    logic [15:0] alarm_one_threshold;
    logic [15:0] alarm_two_threshold;
    logic [15:0] alarm_one_sample_count;
    logic [15:0] alarm_two_sample_count;
    logic [15:0] alarm_configuration;
    logic [3:0]  sel_one;
    logic [3:0]  sel_two;
    logic [15:0] val_one;
    logic [15:0] val_two;
    logic        sgn_one;
    logic        sgn_two;
    logic        flag_one;
    logic        flag_two;
    logic        any_flag;
    logic        ind_on;
    logic        ind_level;
    logic        claim_one;
    logic        claim_two;
    logic [15:0] rate_pick;

    // register writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alarm_one_threshold    <= dcam_pkg::REG_RESET;
            alarm_two_threshold    <= dcam_pkg::REG_RESET;
            alarm_one_sample_count <= dcam_pkg::REG_RESET;
            alarm_two_sample_count <= dcam_pkg::REG_RESET;
            alarm_configuration    <= dcam_pkg::REG_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                dcam_pkg::OFS_THR_ONE: alarm_one_threshold    <= reg_wdata;
                dcam_pkg::OFS_THR_TWO: alarm_two_threshold    <= reg_wdata;
                dcam_pkg::OFS_CNT_ONE: alarm_one_sample_count <= reg_wdata;
                dcam_pkg::OFS_CNT_TWO: alarm_two_sample_count <= reg_wdata;
                dcam_pkg::OFS_CONFIG:  alarm_configuration    <= reg_wdata;
                default: ;
            endcase
        end
    end

    // register reads, unmapped offsets return zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            reg_rdata <= 16'h0000;
        else begin
            unique case (reg_addr)
                dcam_pkg::OFS_THR_ONE: reg_rdata <= alarm_one_threshold;
                dcam_pkg::OFS_THR_TWO: reg_rdata <= alarm_two_threshold;
                dcam_pkg::OFS_CNT_ONE: reg_rdata <= alarm_one_sample_count;
                dcam_pkg::OFS_CNT_TWO: reg_rdata <= alarm_two_sample_count;
                dcam_pkg::OFS_CONFIG:  reg_rdata <= alarm_configuration;
                default:               reg_rdata <= 16'h0000;
            endcase
        end
    end

    // source selection per alarm
    assign sel_one   = alarm_configuration[dcam_pkg::SEL_ONE_HI:dcam_pkg::SEL_ONE_LO];
    assign sel_two   = alarm_configuration[dcam_pkg::SEL_TWO_HI:dcam_pkg::SEL_TWO_LO];
    assign rate_pick = alarm_configuration[dcam_pkg::BIT_FILTER] ?
                       rate_output_filtered : rate_output_coarse;

    always_comb begin
        val_one = 16'h0000;
        val_two = 16'h0000;
        sgn_one = 1'b0;
        sgn_two = 1'b0;
        unique case (sel_one)
            dcam_pkg::DCAM_SRC_RATE: begin val_one = rate_pick; sgn_one = 1'b1; end
            dcam_pkg::DCAM_SRC_TEMP: begin val_one = temperature_output; sgn_one = 1'b1; end
            dcam_pkg::DCAM_SRC_DIAG: val_one = diagnostic_status_word;
            default: ;
        endcase
        unique case (sel_two)
            dcam_pkg::DCAM_SRC_RATE: begin val_two = rate_pick; sgn_two = 1'b1; end
            dcam_pkg::DCAM_SRC_TEMP: begin val_two = temperature_output; sgn_two = 1'b1; end
            dcam_pkg::DCAM_SRC_DIAG: val_two = diagnostic_status_word;
            default: ;
        endcase
    end

    // alarm one
    dcam_channel u_alarm_one (
        .mclk         (mclk),
        .rst          (rst),
        .sample_valid (sample_valid),
        .enable       (sel_one inside {4'h1, 4'h2, 4'h3}),
        .is_signed    (sgn_one),
        .value        (val_one),
        .threshold    (alarm_one_threshold),
        .count_reg    (alarm_one_sample_count),
        .rate_mode    (alarm_configuration[dcam_pkg::BIT_MODE_ONE]),
        .above        (alarm_configuration[dcam_pkg::BIT_DIR_ONE]),
        .flag         (flag_one)
    );

    // alarm two
    dcam_channel u_alarm_two (
        .mclk         (mclk),
        .rst          (rst),
        .sample_valid (sample_valid),
        .enable       (sel_two inside {4'h1, 4'h2, 4'h3}),
        .is_signed    (sgn_two),
        .value        (val_two),
        .threshold    (alarm_two_threshold),
        .count_reg    (alarm_two_sample_count),
        .rate_mode    (alarm_configuration[dcam_pkg::BIT_MODE_TWO]),
        .above        (alarm_configuration[dcam_pkg::BIT_DIR_TWO]),
        .flag         (flag_two)
    );

    assign alarm_flags = {flag_two, flag_one};

    // diagnostic word with alarm flags merged in
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            diagnostic_status_word <= 16'h0000;
        else begin
            diagnostic_status_word <= diag_status_in;
            diagnostic_status_word[dcam_pkg::DIAG_FLAG_ONE] <= flag_one;
            diagnostic_status_word[dcam_pkg::DIAG_FLAG_TWO] <= flag_two;
        end
    end

    // indicator routing; data ready wins its line
    assign any_flag  = flag_one | flag_two;
    assign ind_on    = alarm_configuration[dcam_pkg::BIT_IND_EN];
    assign ind_level = alarm_configuration[dcam_pkg::BIT_IND_POL] ? any_flag : !any_flag;
    assign claim_one = data_ready_enable && !data_ready_line_two;
    assign claim_two = data_ready_enable && data_ready_line_two;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            digital_line_one_out <= 1'b0;
            digital_line_one_oe  <= 1'b0;
            digital_line_two_out <= 1'b0;
            digital_line_two_oe  <= 1'b0;
        end else begin
            digital_line_one_oe  <= ind_on && !alarm_configuration[dcam_pkg::BIT_IND_LINE]
                                    && !claim_one;
            digital_line_two_oe  <= ind_on && alarm_configuration[dcam_pkg::BIT_IND_LINE]
                                    && !claim_two;
            digital_line_one_out <= ind_level;
            digital_line_two_out <= ind_level;
        end
    end

    property p_diag_flags;
        @(posedge mclk) disable iff (rst)
            1'b1 |=> diagnostic_status_word[9:8] == $past(alarm_flags);
    endproperty
    a_diag_flags: assert property (p_diag_flags) else $error("diag flags mismatch");

    property p_yield_line;
        @(posedge mclk) disable iff (rst)
            (claim_one || claim_two) |=> !(($past(claim_one) && digital_line_one_oe)
                                        || ($past(claim_two) && digital_line_two_oe));
    endproperty
    a_yield_line: assert property (p_yield_line) else $error("indicator took data ready line");

    sequence s_ind_driving;
        ind_on && !claim_one && !claim_two;
    endsequence
    property p_polarity;
        @(posedge mclk) disable iff (rst)
            s_ind_driving |=> (digital_line_one_oe || digital_line_two_oe)
                && (digital_line_one_out == ($past(alarm_configuration[1]) ~^ $past(any_flag)));
    endproperty
    a_polarity: assert property (p_polarity) else $error("indicator level wrong");

    property p_off_when_disabled;
        @(posedge mclk) disable iff (rst)
            !ind_on |=> !digital_line_one_oe && !digital_line_two_oe;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled) else $error("indicator on");

    property p_write_read;
        @(posedge mclk) disable iff (rst)
            (reg_wr && reg_addr == dcam_pkg::OFS_CONFIG) ##1 (!reg_wr && reg_addr ==
                dcam_pkg::OFS_CONFIG) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_write_read: assert property (p_write_read) else $error("config readback wrong");
endmodule // dcam_monitor

// file: tb/dcam_monitor_tb.sv
module dcam_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        sample_valid = 1'b0;
    logic [15:0] rate_output_coarse = 16'h0000;
    logic [15:0] rate_output_filtered = 16'h0000;
    logic [15:0] temperature_output = 16'h0000;
    logic [15:0] diag_status_in = 16'h0000;
    logic        data_ready_enable = 1'b0;
    logic        data_ready_line_two = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0]  alarm_flags;
    logic [15:0] diagnostic_status_word;
    logic        digital_line_one_out;
    logic        digital_line_one_oe;
    logic        digital_line_two_out;
    logic        digital_line_two_oe;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          seed_dummy;
    logic [15:0] cfg;
    logic [15:0] thr [2];
    logic [15:0] cnt [2];
    logic [16:0] hist [2][$];
    logic [1:0]  exp_q, exp_d1;
    logic [15:0] dw;
    logic [7:0]  offs [5] = '{dcam_pkg::OFS_THR_ONE, dcam_pkg::OFS_THR_TWO,
                              dcam_pkg::OFS_CNT_ONE, dcam_pkg::OFS_CNT_TWO, dcam_pkg::OFS_CONFIG};

    dcam_monitor dut_u (
        .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid),
        .rate_output_coarse(rate_output_coarse), .rate_output_filtered(rate_output_filtered),
        .temperature_output(temperature_output), .diag_status_in(diag_status_in),
        .data_ready_enable(data_ready_enable), .data_ready_line_two(data_ready_line_two),
        .alarm_flags(alarm_flags), .diagnostic_status_word(diagnostic_status_word),
        .digital_line_one_out(digital_line_one_out), .digital_line_one_oe(digital_line_one_oe),
        .digital_line_two_out(digital_line_two_out), .digital_line_two_oe(digital_line_two_oe)
    );

    // clock and hang guard
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // register write, leaves strobe high for back-to-back use
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_wr = 1'b0;
        reg_addr = a;
        @(posedge mclk);
        @(negedge mclk);
        check(reg_rdata, e);
    endtask

    // expectation helpers
    function automatic logic [3:0] sel_of(input int i);
        return i ? cfg[15:12] : cfg[11:8];
    endfunction
    function automatic logic [16:0] ext(input int i, input logic [15:0] v);
        return (sel_of(i) == 4'h3) ? {1'b0, v} : {v[15], v};
    endfunction
    function automatic logic [16:0] src(input int i);
        case (sel_of(i))
            4'h1: return ext(i, cfg[3] ? rate_output_filtered : rate_output_coarse);
            4'h2: return ext(i, temperature_output);
            default: return ext(i, dw);
        endcase
    endfunction
    function automatic logic hit(input int i, input logic [16:0] a);
        if (cfg[4 + i]) return $signed(a) > $signed(ext(i, thr[i]));
        return $signed(a) < $signed(ext(i, thr[i]));
    endfunction
    function automatic logic own();
        return cfg[2] && !(data_ready_enable && (data_ready_line_two == cfg[0]));
    endfunction

    // one cycle of sensor data, then compare flags, status word and lines
    task automatic step(input logic sv);
        int          n;
        logic [16:0] cur;
        logic [15:0] dexp;
        logic [1:0]  oe_exp;
        logic        lvl;
        // alarms see the registered word: last cycle's input, flags two cycles back
        dw = diag_status_in;
        dw[9:8] = exp_d1;
        sample_valid = sv;
        rate_output_coarse = 16'($urandom_range(0, 200) - 100);
        rate_output_filtered = 16'($urandom_range(0, 200) - 100);
        temperature_output = 16'($urandom_range(0, 200) - 100);
        diag_status_in = 16'($urandom);
        exp_d1 = exp_q;
        for (int i = 0; i < 2; i++) begin
            n = (cnt[i][7:0] == 8'h00) ? 1 : int'(cnt[i][7:0]);
            if (sel_of(i) == 4'h0 || sel_of(i) > 4'h3) begin
                exp_q[i] = 1'b0;
            end else if (sv) begin
                cur = src(i);
                hist[i].push_back(cur);
                if (!cfg[6 + i]) begin
                    exp_q[i] = hit(i, cur);
                end else if (hist[i].size() > n) begin
                    exp_q[i] = hit(i, cur - hist[i][hist[i].size() - 1 - n]);
                    void'(hist[i].pop_front());
                end else begin
                    exp_q[i] = 1'b0;
                end
            end
        end
        @(posedge mclk);
        @(negedge mclk);
        dexp = diag_status_in;
        dexp[9:8] = exp_d1;
        oe_exp = own() ? {cfg[0], !cfg[0]} : 2'b00;
        lvl = cfg[1] ? |exp_d1 : ~|exp_d1;
        check(16'(alarm_flags), 16'(exp_q));
        check(diagnostic_status_word, dexp);
        check(16'({digital_line_two_oe, digital_line_one_oe}), 16'(oe_exp));
        check(16'({digital_line_two_out, digital_line_one_out}), 16'({lvl, lvl}));
    endtask

    // disable, program, read back, then run samples
    task automatic trial(input logic [15:0] c, t0, t1, s0, s1);
        logic [15:0] vals [5];
        wr(dcam_pkg::OFS_CONFIG, 16'h0000);
        reg_wr = 1'b0;
        @(negedge mclk);
        @(negedge mclk);
        cfg = c;
        thr = '{t0, t1};
        cnt = '{s0, s1};
        vals = '{t0, t1, s0, s1, c};
        data_ready_enable = 1'($urandom_range(0, 1));
        data_ready_line_two = 1'($urandom_range(0, 1));
        for (int j = 0; j < 5; j++) wr(offs[j], vals[j]);
        wr(8'h1a, 16'($urandom));
        for (int j = 0; j < 5; j++) rd(offs[j], vals[j]);
        rd(8'h1a, 16'h0000);
        hist[0].delete();
        hist[1].delete();
        exp_q = 2'b00;
        exp_d1 = 2'b00;
        repeat (30) step($urandom_range(0, 3) != 0);
        sample_valid = 1'b0;
    endtask

    // reset, corner trials, then random trials
    initial begin
        seed_dummy = $urandom(32'h9bba4e59);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check(16'({alarm_flags, digital_line_one_oe, digital_line_two_oe}), 16'h0000);
        rst = 1'b0;
        for (int j = 0; j < 5; j++) rd(offs[j], dcam_pkg::REG_RESET);
        trial(16'h3157, 16'h8000, 16'h0000, 16'hff00, 16'h0001);
        trial(16'h21ee, 16'h0000, 16'h0005, 16'h0000, 16'h0102);
        trial(16'h3224, 16'h7fff, 16'h8000, 16'h0000, 16'h0000);
        // second reset in mid-run, programmed registers fall back to zero
        rst = 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        check(16'({alarm_flags, digital_line_one_oe, digital_line_two_oe}), 16'h0000);
        rst = 1'b0;
        for (int j = 0; j < 5; j++) rd(offs[j], dcam_pkg::REG_RESET);
        repeat (40) trial({4'($urandom_range(0, 4)), 4'($urandom_range(0, 4)), 8'($urandom)},
                          16'($urandom_range(0, 128) - 64), 16'($urandom_range(0, 128) - 64),
                          {8'($urandom), 8'($urandom_range(0, 6))},
                          {8'($urandom), 8'($urandom_range(0, 6))});
        close_out();
    end
endmodule // dcam_monitor_tb
